// >>> core/cfg_word_two_pkg.sv
package cfg_word_two_pkg;
   // ----------------------------------------
   // word layout
   // ----------------------------------------
   localparam int WORD_W          = 24;
   localparam int ADDR_W          = 4;
   localparam int DATA_W          = 32;
   localparam int TWO_SPEED_BIT   = 15;
   localparam int RESV_ZERO_BIT   = 14;
   localparam int WDT_MUX_BIT     = 13;
   localparam int ALT_CMP_BIT     = 12;
   localparam int ALT_PIN_BIT     = 11;
   localparam int OSC_SEL_LO      = 8;
   localparam int OSC_SEL_HI      = 10;
   localparam int CLK_SUP_LO      = 6;
   localparam int CLK_SUP_HI      = 7;
   localparam int WDT_SRC_LO      = 3;
   localparam int WDT_SRC_HI      = 4;
   localparam int RESV_ONE_BIT    = 2;
   localparam int UNIMPL_LO       = 16;
   localparam int UNIMPL_HI       = 23;
   localparam logic [7:0] UNIMPL_ONES = 8'hff;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [ADDR_W-1:0] CFG_WORD_ADDR  = 4'h0;
   localparam logic [ADDR_W-1:0] CFG_STATE_ADDR = 4'h4;
   localparam logic [ADDR_W-1:0] CFG_RUN_ADDR   = 4'h8;
   localparam logic [WORD_W-1:0] CFG_ERASED     = 24'hffffff;
   // ----------------------------------------
   // encodings
   // ----------------------------------------
   typedef enum logic [2:0] {
      OSC_FAST_RC       = 3'h0,
      OSC_FAST_RC_PLL   = 3'h1,
      OSC_PRIMARY       = 3'h2,
      OSC_PRIMARY_PLL   = 3'h3,
      OSC_SECONDARY     = 3'h4,
      OSC_LOW_POWER_RC  = 3'h5,
      OSC_RESERVED      = 3'h6,
      OSC_FAST_RC_DIV   = 3'h7
   } osc_sel_t;
   typedef enum logic [1:0] {
      WCLK_LOW_POWER_RC = 2'h0,
      WCLK_FAST_RC_31K  = 2'h1,
      WCLK_FROM_FIELD   = 2'h2
   } wdt_clk_t;
   typedef enum {ST_LOAD, ST_RUN} load_state_t;
endpackage : cfg_word_two_pkg

// >>> core/cfg_sync_reset.sv
`timescale 1ns/100ps
module cfg_sync_reset (
   input  wire logic clk,          // system clock
   input  wire logic arst_n,       // async reset, active low
   output logic      rst_n         // released copy
);
   logic meta_reg;
   // ----------------------------------------
   // release through two flops
   // ----------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_reg <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         meta_reg <= 1'b1;
         rst_n    <= meta_reg;  // only the second flop reads the first
      end
   end
endmodule : cfg_sync_reset

// >>> core/boot_config_word_two_decode.sv
`timescale 1ns/100ps
// Operation
// [RL1] bits 23 to 16 are unimplemented and always read as ones
// [RL2] bit 15 set enables two-speed start-up from internal clock
// [RL3] bit 14 is reserved and always reads as zero; a read in the ST_LOAD cycle returns the erased word with it set
// [RL4] bit 13 set takes watchdog clock from field, else low-power RC
// [RL5] bit 12 set spreads comparator C-inputs to three pins, else one
// [RL6] bit 11 set appends relocatable pin functions to other pin
// [RL7] programmer keeps bit 11 set when bus-power sensing is used
// [RL8] bits 10 to 8 select the initial oscillator per encoding
// [RL9] bits 7 to 6: 1x none, 01 switching, 00 switching and monitor
// [RL10] windowed watchdog uses 31 kHz fast RC unless RC is system clock; the decode picks low-power RC whenever sleep_mode is set
// [RL11] word is latched at reset exit and held read-only afterward
module boot_config_word_two_decode
   import cfg_word_two_pkg::*;
(
   input  wire logic                          clk,       // 125 MHz
   input  wire logic                          arst_n,    // async reset
   input  wire logic [cfg_word_two_pkg::WORD_W-1:0] cfg_word_in, // stored word
   input  wire logic                          sleep_mode,     // core sleeps
   input  wire logic                          wdt_windowed,   // window mode
   input  wire logic [cfg_word_two_pkg::ADDR_W-1:0] addr,     // reg address
   input  wire logic [cfg_word_two_pkg::DATA_W-1:0] wdata,    // write data
   input  wire logic                          wr_stb,    // write strobe
   input  wire logic                          rd_stb,    // read strobe
   output logic [cfg_word_two_pkg::DATA_W-1:0] rdata,    // read data
   output logic                               cfg_valid,     // word latched
   output logic                               two_speed_startup_enable, // tss
   output logic                               watchdog_clock_mux_select,// mux
   output logic [1:0]                         watchdog_clock_source_field,
   output logic [1:0]                         wdt_clock_choice, // wdt_clk_t
   output logic                               alternate_comparator_input_select,
   output logic [2:0]                         cmp_c_input_pin_sel, // pin mask
   output logic                               alternate_pin_function_enable,
   output logic                               relocatable_pin_on_alt, // moved
   output logic [2:0]                         initial_oscillator_select,
   output logic                               osc_select_reserved, // 110
   output logic                               clock_switch_enable, // switch
   output logic                               fail_safe_monitor_enable,
   output logic [1:0]                         clock_switch_monitor_config,
   output logic                               run_clock_is_low_power_rc_oscillator // low_power_rc_oscillator in use
);
   import cfg_word_two_pkg::*;

   logic                rst_n;
   load_state_t         state_reg;
   logic [WORD_W-1:0]   word_reg;
   logic [2:0]          run_osc_reg;
   logic [2:0]          run_osc_next;

   // ----------------------------------------
   // reset release
   // ----------------------------------------
   cfg_sync_reset u_rst (
      .clk    (clk),
      .arst_n (arst_n),
      .rst_n  (rst_n)
   );

   // clean view of the word: bits 23 to 16 and bit 14 forced regardless of storage; bit 2 is passed as stored
   function automatic logic [WORD_W-1:0] shape(input logic [WORD_W-1:0] w);
      logic [WORD_W-1:0] s;
      s = w;
      s[UNIMPL_HI:UNIMPL_LO] = UNIMPL_ONES;  // [RL1]
      s[RESV_ZERO_BIT]       = 1'b0;         // [RL3]
      return s;
   endfunction : shape

   // ----------------------------------------
   // one-shot load after reset release
   // ----------------------------------------
   // word is read once; later changes on cfg_word_in are ignored
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_LOAD;
         word_reg  <= CFG_ERASED;
         cfg_valid <= 1'b0;
      end else begin
         case (state_reg)
            ST_LOAD: begin
               word_reg  <= shape(cfg_word_in);  // [RL11]
               cfg_valid <= 1'b1;
               state_reg <= ST_RUN;
            end
            default: begin
               state_reg <= ST_RUN;               // [RL11] held constant
            end
         endcase
      end
   end

   // ----------------------------------------
   // running oscillator, starts on the chosen source
   // ----------------------------------------
   // software may ask for a switch only if switching is enabled
   always_comb begin
      run_osc_next = run_osc_reg;
      if (state_reg == ST_LOAD) begin
         run_osc_next = cfg_word_in[OSC_SEL_HI:OSC_SEL_LO];
      end else if (wr_stb && addr == CFG_RUN_ADDR && clock_switch_enable
                   && wdata[2:0] != OSC_RESERVED) begin
         run_osc_next = wdata[2:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         run_osc_reg       <= OSC_FAST_RC_DIV;
         run_clock_is_low_power_rc_oscillator <= 1'b0;
      end else begin
         run_osc_reg       <= run_osc_next;
         run_clock_is_low_power_rc_oscillator <= (run_osc_next == OSC_LOW_POWER_RC);
      end
   end

   // ----------------------------------------
   // field decode into static controls
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         two_speed_startup_enable          <= 1'b0;
         watchdog_clock_mux_select         <= 1'b0;
         watchdog_clock_source_field       <= 2'h0;
         alternate_comparator_input_select <= 1'b0;
         cmp_c_input_pin_sel               <= 3'h0;
         alternate_pin_function_enable     <= 1'b0;
         relocatable_pin_on_alt            <= 1'b0;
         initial_oscillator_select         <= OSC_FAST_RC_DIV;
         osc_select_reserved               <= 1'b0;
         clock_switch_monitor_config       <= 2'h3;
         clock_switch_enable               <= 1'b0;
         fail_safe_monitor_enable          <= 1'b0;
      end else begin
         two_speed_startup_enable  <= word_reg[TWO_SPEED_BIT];      // [RL2]
         watchdog_clock_mux_select <= word_reg[WDT_MUX_BIT];        // [RL4]
         watchdog_clock_source_field <= word_reg[WDT_SRC_HI:WDT_SRC_LO];
         alternate_comparator_input_select <= word_reg[ALT_CMP_BIT];
         // pin mask: three separate, or all on the shared pin
         cmp_c_input_pin_sel <= word_reg[ALT_CMP_BIT] ? 3'h7 : 3'h1; // [RL5]
         // bit held at one by the programmer when bus power is sensed
         alternate_pin_function_enable <= word_reg[ALT_PIN_BIT];    // [RL7]
         relocatable_pin_on_alt        <= word_reg[ALT_PIN_BIT];    // [RL6]
         initial_oscillator_select <= word_reg[OSC_SEL_HI:OSC_SEL_LO]; // [RL8]
         osc_select_reserved <=
            word_reg[OSC_SEL_HI:OSC_SEL_LO] == OSC_RESERVED;        // [RL8]
         clock_switch_monitor_config <= word_reg[CLK_SUP_HI:CLK_SUP_LO];
         clock_switch_enable      <= !word_reg[CLK_SUP_HI];         // [RL9]
         fail_safe_monitor_enable <=
            word_reg[CLK_SUP_HI:CLK_SUP_LO] == 2'h0;                // [RL9]
      end
   end

   // ----------------------------------------
   // watchdog clock choice
   // ----------------------------------------
   // field value itself is left to the watchdog; we only flag the route
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wdt_clock_choice <= WCLK_LOW_POWER_RC;
      end else if (!word_reg[WDT_MUX_BIT]) begin
         wdt_clock_choice <= WCLK_LOW_POWER_RC;                     // [RL4]
      end else if (wdt_windowed && !sleep_mode
                   && run_osc_reg != OSC_LOW_POWER_RC) begin
         wdt_clock_choice <= WCLK_FAST_RC_31K;                      // [RL10]
      end else if (sleep_mode) begin
         wdt_clock_choice <= WCLK_LOW_POWER_RC;                     // [RL10]
      end else begin
         wdt_clock_choice <= WCLK_FROM_FIELD;
      end
   end

   // ----------------------------------------
   // register read port, one cycle latency
   // ----------------------------------------
   // writes to the word are ignored: it is program-once
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= '0;
      end else if (rd_stb) begin
         if (addr == CFG_WORD_ADDR) begin
            rdata <= {8'h00, word_reg};                     // [RL1] [RL3]
         end else if (addr == CFG_STATE_ADDR) begin
            rdata <= {29'h0, osc_select_reserved, cfg_valid,
                      (state_reg == ST_RUN)};
         end else if (addr == CFG_RUN_ADDR) begin
            rdata <= {29'h0, run_osc_reg};
         end else begin
            rdata <= '0;
         end
      end else begin
         rdata <= '0;
      end
   end
endmodule : boot_config_word_two_decode

// >>> tb/cfg_word_two_monitor.sv
`timescale 1ns/100ps
module cfg_word_two_monitor
   import cfg_word_two_pkg::*;
(
   input wire logic                        clk,
   input wire logic                        arst_n,
   input wire logic                        sleep_mode,
   input wire logic                        wdt_windowed,
   input wire logic [cfg_word_two_pkg::ADDR_W-1:0] addr,
   input wire logic                        wr_stb,
   input wire logic                        rd_stb,
   input wire logic [cfg_word_two_pkg::DATA_W-1:0] rdata,
   input wire logic                        cfg_valid,
   input wire logic                        two_speed_startup_enable,
   input wire logic                        watchdog_clock_mux_select,
   input wire logic [1:0]                  wdt_clock_choice,
   input wire logic                        alternate_comparator_input_select,
   input wire logic [2:0]                  cmp_c_input_pin_sel,
   input wire logic                        alternate_pin_function_enable,
   input wire logic                        relocatable_pin_on_alt,
   input wire logic [2:0]                  initial_oscillator_select,
   input wire logic                        osc_select_reserved,
   input wire logic                        clock_switch_enable,
   input wire logic                        fail_safe_monitor_enable,
   input wire logic [1:0]                  clock_switch_monitor_config,
   input wire logic                        run_clock_is_low_power_rc_oscillator
);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   // decoded outputs may lag cfg_valid by an edge, so gate on its past
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   property p_unimpl;
      cfg_valid && rd_stb && addr == CFG_WORD_ADDR |=> rdata[23:16] == 8'hff;
   endproperty
   a_unimpl: assert property (p_unimpl)
      else $error("upper byte not ones");
   property p_resv;
      cfg_valid && rd_stb && addr == CFG_WORD_ADDR |=> !rdata[14];
   endproperty
   a_resv: assert property (p_resv)
      else $error("reserved bit not zero");
   property p_held;
      // decoded outputs settle one edge after the latch, so skip that edge
      cfg_valid && $past(cfg_valid, 2) |-> $stable(two_speed_startup_enable)
         && $stable(initial_oscillator_select);
   endproperty
   a_held: assert property (p_held)
      else $error("latched field moved");
   property p_mux;
      $past(cfg_valid, 2) && !watchdog_clock_mux_select
         |-> wdt_clock_choice == WCLK_LOW_POWER_RC;
   endproperty
   a_mux: assert property (p_mux)
      else $error("watchdog not on low-power rc");
   property p_cmp;
      $past(cfg_valid) |-> cmp_c_input_pin_sel ==
         (alternate_comparator_input_select ? 3'h7 : 3'h1);
   endproperty
   a_cmp: assert property (p_cmp)
      else $error("comparator pin choice wrong");
   property p_pin;
      relocatable_pin_on_alt == alternate_pin_function_enable;
   endproperty
   a_pin: assert property (p_pin)
      else $error("pin function move wrong");
   property p_oscres;
      osc_select_reserved == (initial_oscillator_select == 3'h6);
   endproperty
   a_oscres: assert property (p_oscres)
      else $error("reserved oscillator flag wrong");
   property p_sup;
      clock_switch_enable == !clock_switch_monitor_config[1] &&
      fail_safe_monitor_enable == (clock_switch_monitor_config == 2'h0);
   endproperty
   a_sup: assert property (p_sup)
      else $error("clock supervision decode wrong");
   property p_fast;
      $past(cfg_valid, 2) && !$past(wr_stb) && !$past(wr_stb, 2) &&
      $past(watchdog_clock_mux_select && wdt_windowed && !sleep_mode &&
      !run_clock_is_low_power_rc_oscillator) |-> wdt_clock_choice == WCLK_FAST_RC_31K;
   endproperty
   a_fast: assert property (p_fast)
      else $error("windowed watchdog not on fast rc");
endmodule : cfg_word_two_monitor

bind boot_config_word_two_decode cfg_word_two_monitor mon (.*);

// >>> tb/boot_config_word_two_decode_bench.sv
`timescale 1ns/100ps
module boot_config_word_two_decode_bench;
   import cfg_word_two_pkg::*;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic clk = 1'b0, arst_n = 1'b0, sleep_mode = 1'b0, wdt_windowed = 1'b0;
   logic wr_stb = 1'b0, rd_stb = 1'b0;
   logic [ADDR_W-1:0] addr = 4'h0;
   logic [DATA_W-1:0] wdata = 32'h0, rdata, d;
   logic [WORD_W-1:0] cfg_word_in = 24'h0, w;
   logic [2:0] run, v, initial_oscillator_select, cmp_c_input_pin_sel;
   logic [1:0] watchdog_clock_source_field, wdt_clock_choice;
   logic [1:0] clock_switch_monitor_config;
   logic cfg_valid, two_speed_startup_enable, watchdog_clock_mux_select;
   logic alternate_comparator_input_select, alternate_pin_function_enable;
   logic relocatable_pin_on_alt, osc_select_reserved, clock_switch_enable;
   logic fail_safe_monitor_enable, run_clock_is_low_power_rc_oscillator;
   int   error_cnt = 0, total_checks = 0;

   boot_config_word_two_decode dut (.*);

   // 125 MHz clock
   initial forever #4 clk = ~clk;

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] x);
      @(posedge clk);
      addr <= a;
      wdata <= x;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask : wr
   // data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [31:0] x);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      @(negedge clk);
      x = rdata;
   endtask : rd
   task automatic settle();
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask : settle
   function automatic logic [1:0] wdt_exp(input logic s, win, lp);
      if (!w[13]) return WCLK_LOW_POWER_RC;
      if (win && !s && !lp) return WCLK_FAST_RC_31K;
      if (s) return WCLK_LOW_POWER_RC;
      return WCLK_FROM_FIELD;
   endfunction : wdt_exp
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_sim

   // ----------------------------------------
   // tests: one power-on per word
   // ----------------------------------------
   initial begin
      void'($urandom(32'h190e));
      repeat (12) @(posedge clk);
      for (int i = 0; i < 10; i++) begin
         w = $urandom;
         w[10:8] = i[2:0];
         w[7:6] = i[1:0];
         @(posedge clk);
         arst_n <= 1'b0;
         cfg_word_in <= w;
         @(posedge clk);
         arst_n <= 1'b1;
         repeat (5) @(posedge clk);
         @(negedge clk);
         run = w[10:8];
         chk(cfg_valid, 1'b1);
         chk(two_speed_startup_enable, w[15]);
         chk(watchdog_clock_mux_select, w[13]);
         chk(cmp_c_input_pin_sel, w[12] ? 3'h7 : 3'h1);
         chk(alternate_pin_function_enable, w[11]);
         chk(osc_select_reserved, w[10:8] == 3'h6);
         chk(clock_switch_monitor_config, w[7:6]);
         chk(watchdog_clock_source_field, w[4:3]);
         chk(alternate_comparator_input_select, w[12]);
         chk(relocatable_pin_on_alt, w[11]);
         chk(initial_oscillator_select, run);
         chk(fail_safe_monitor_enable, w[7:6] == 2'h0);
         chk(clock_switch_enable, !w[7]);
         rd(CFG_WORD_ADDR, d);
         chk(d, {8'h00, 8'hff, w[15], 1'b0, w[13:0]});
         rd(CFG_STATE_ADDR, d);
         chk(d, {29'h0, w[10:8] == 3'h6, 2'b11});
         // a changed source and a write must not disturb the latch
         @(posedge clk);
         cfg_word_in <= ~w;
         wr(CFG_WORD_ADDR, $urandom);
         rd(CFG_WORD_ADDR, d);
         chk(d[15:0], {w[15], 1'b0, w[13:0]});
         rd(4'hc, d);
         chk(d, 32'h0);
         v = $urandom;
         wr(CFG_RUN_ADDR, {29'h0, v});
         if (!w[7] && v != 3'h6)
            run = v;
         settle();
         chk(run_clock_is_low_power_rc_oscillator, run == 3'h5);
         rd(CFG_RUN_ADDR, d);
         chk(d[2:0], run);
         for (int j = 0; j < 4; j++) begin
            @(posedge clk);
            sleep_mode <= j[0];
            wdt_windowed <= j[1];
            settle();
            chk(wdt_clock_choice, wdt_exp(j[0], j[1], run == 3'h5));
         end
         $display("test %0d done", i);
      end
      end_sim();
   end

   // hang guard, far beyond the expected few microseconds
   initial begin
      #20000;
      error_cnt++;
      end_sim();
   end
endmodule : boot_config_word_two_decode_bench
